// ---- src/ssd_driver.v ----
// Serial-input segment driver: frame receiver, output latches and frame buffer.
`timescale 1ns/1ps
`include "ssd_map.vh"

// Operation
// - Data arrives on only a data line and a shift clock, no load strobe.
// - On the 36th clock, clock high, all 35 bits load into the latches.
// - In the low phase of that 36th clock every shift stage is cleared.
// - The clear stores nothing from the data pin; the next rise takes a fresh start bit, allowing back-to-back frames.
// - Power-up reset clears every shift stage and every output latch.
// - After reset, a start bit with the first clock resumes reception.
// - First data bit after the start bit drives output one, then in order.
// - A latched one switches its segment on; a zero leaves it off.
// - Latches hold between loads; outputs change only where new bits differ.
// - With a data-enable input, it replaces the 35th output.
module ssd_driver #(
  parameter NUM_BITS = `SSD_NUM_BITS,
  parameter HAS_ENABLE = 1,
  parameter LED_VARIANT = 1
) (
  // System clock and reset
  input wire clk,
  input wire arst_n,
  // Serial link from the data source
  input wire sclk,
  input wire sdata,
  input wire data_en,
  // Segment drive
  output wire [NUM_BITS-1:0] seg_out,
  // Copy of each loaded frame that finds room in the buffer, for a downstream consumer
  output wire [NUM_BITS-1:0] frame_data,
  output wire frame_valid,
  input wire frame_ready,
  // Status
  output wire frame_loaded,
  output wire frame_overrun,
  output wire frame_busy,
  output wire sclk_too_fast
);

  localparam IDX_W = `SSD_IDX_W;
  localparam GAP_W = `SSD_GAP_W;

  // Receiver states.
  localparam ST_IDLE = 2'b00;
  localparam ST_SHIFT = 2'b01;
  localparam ST_CLEAR = 2'b10;

  // Fewest system cycles allowed between two rising shift clock edges.
  // A rise exactly one minimum period after the previous one sees gap_q equal to MIN_GAP, which is legal.
  localparam integer MIN_CYC = LED_VARIANT ? `SSD_LED_MIN_CYC : `SSD_VF_MIN_CYC;
  localparam [31:0] MIN_CYC_V = MIN_CYC;
  localparam [GAP_W-1:0] MIN_GAP = MIN_CYC_V[GAP_W-1:0] - 1'b1;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [IDX_W-1:0] idx_q;
  reg [IDX_W-1:0] idx_d;
  reg [NUM_BITS-1:0] sr_q;
  reg [NUM_BITS-1:0] sr_d;
  reg [NUM_BITS-1:0] latch_q;
  reg [NUM_BITS-1:0] latch_d;
  reg load_q;
  reg load_d;
  reg sclk_q;
  reg overrun_q;
  reg too_fast_q;
  reg [GAP_W-1:0] gap_q;
  reg [NUM_BITS-1:0] seg_q;

  wire link_en;
  wire sclk_rise;
  wire sclk_fall;
  wire [NUM_BITS-1:0] sr_shifted;
  wire push_ready;
  wire [NUM_BITS-1:0] seg_mask;

  // Writes one bit into a vector at a given position.
  function [NUM_BITS-1:0] put_bit;
    input [NUM_BITS-1:0] v;
    input [IDX_W-1:0] pos;
    input b;
    integer i;
    begin
      put_bit = v;
      for (i = 0; i < NUM_BITS; i = i + 1)
      begin
        if (i == pos)
          put_bit[i] = b;
      end
    end
  endfunction

  // One edge decoder serves both directions. It only reports a change while
  // the link listens, so a disabled link can never advance the receiver.
  function edge_seen;
    input en;
    input now_lvl;
    input prev_lvl;
    begin
      edge_seen = en & (now_lvl ^ prev_lvl);
    end
  endfunction

  // True for the stage that takes the last data bit of a frame.
  function last_bit;
    input [IDX_W-1:0] pos;
    begin
      last_bit = (pos == `SSD_LAST_IDX);
    end
  endfunction

  // Without a data-enable pin the link is always listening.
  assign link_en = (HAS_ENABLE != 0) ? data_en : 1'b1;

  // The link pins are sampled synchronously, so a plain edge detector suffices.
  // Edges seen while disabled are dropped, but sclk_q keeps tracking so that
  // re-enabling with the clock high does not fake a rising edge.
  assign sclk_rise = edge_seen(link_en, sclk, sclk_q) & sclk;
  assign sclk_fall = edge_seen(link_en, sclk, sclk_q) & ~sclk;

  // Bit k of the frame (counted from one after the start bit) lands in
  // position k-1, which drives output k.
  assign sr_shifted = put_bit(sr_q, idx_q, sdata);

  always @*
  begin
    state_d = state_q;
    idx_d = idx_q;
    sr_d = sr_q;
    latch_d = latch_q;
    load_d = 1'b0;
    case (state_q)
      ST_IDLE:
      begin
        // A frame only starts on a one; zeros on an idle line are not frames.
        if (sclk_rise && sdata)
        begin
          state_d = ST_SHIFT;
          idx_d = `SSD_FIRST_IDX;
        end
      end
      ST_SHIFT:
      begin
        if (sclk_rise)
        begin
          sr_d = sr_shifted;
          if (last_bit(idx_q))
          begin
            // The 36th clock, high phase: all bits move into the latches.
            latch_d = sr_shifted;
            load_d = 1'b1;
            state_d = ST_CLEAR;
          end
          else
          begin
            idx_d = idx_q + 1'b1;
          end
        end
        // A frame cut short simply waits here with its partial contents.
      end
      ST_CLEAR:
      begin
        // Low phase of the 36th clock empties the shift stages. The data pin
        // is not stored here, so the next start bit is taken fresh at the
        // following rising edge and frames may follow with no gap.
        if (sclk_fall)
        begin
          sr_d = `SSD_SR_RESET;
          idx_d = `SSD_FIRST_IDX;
          state_d = ST_IDLE;
        end
        else if (sclk_rise)
        begin
          // The clearing fall came while data-enable was low and was missed.
          // Clear now and let this rising edge stand as a fresh start bit.
          sr_d = `SSD_SR_RESET;
          idx_d = `SSD_FIRST_IDX;
          state_d = sdata ? ST_SHIFT : ST_IDLE;
        end
      end
      default:
      begin
        state_d = ST_IDLE;
        idx_d = `SSD_FIRST_IDX;
        sr_d = `SSD_SR_RESET;
      end
    endcase
  end

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q <= ST_IDLE;
      idx_q <= `SSD_FIRST_IDX;
      sr_q <= `SSD_SR_RESET;
      latch_q <= `SSD_LATCH_RESET;
      load_q <= 1'b0;
      sclk_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      idx_q <= idx_d;
      sr_q <= sr_d;
      latch_q <= latch_d;
      load_q <= load_d;
      sclk_q <= sclk;
    end
  end

  // Shift clock rate watch: counts system cycles between rising edges inside
  // a frame. The source is trusted to keep the limit; this only reports it.
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      gap_q <= `SSD_GAP_MAX;
      too_fast_q <= 1'b0;
    end
    else
    begin
      too_fast_q <= sclk_rise && (state_q != ST_IDLE) && (gap_q < MIN_GAP);
      if (sclk_rise)
        gap_q <= {GAP_W{1'b0}};
      else if (gap_q != `SSD_GAP_MAX)
        gap_q <= gap_q + 1'b1;
    end
  end

  // Every loaded frame is also offered downstream. The serial source cannot be
  // held off, so a frame that meets a full buffer is not queued and the loss
  // is reported; the segment latches themselves are never affected.
  ssd_frame_fifo #(
    .WIDTH(NUM_BITS),
    .DEPTH(`SSD_FIFO_DEPTH),
    .AW(`SSD_FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .arst_n(arst_n),
    .in_valid(load_q),
    .in_ready(push_ready),
    .in_data(latch_q),
    .out_valid(frame_valid),
    .out_ready(frame_ready),
    .out_data(frame_data)
  );

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      overrun_q <= 1'b0;
    else
      overrun_q <= load_q & ~push_ready;
  end

  // Segment drive comes straight from flip-flops; the enable slot is masked
  // before the register so no gate sits between the latch and the pin.
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      seg_q <= `SSD_LATCH_RESET;
    else
      seg_q <= latch_d & seg_mask;
  end

  // With a data-enable pin, the last output position is taken by that pin and
  // is held off.
  genvar g;
  generate
    for (g = 0; g < NUM_BITS; g = g + 1)
    begin : g_mask
      if ((HAS_ENABLE != 0) && (g == `SSD_ENABLE_OUT_POS))
      begin : g_off
        assign seg_mask[g] = 1'b0;
      end
      else
      begin : g_on
        assign seg_mask[g] = 1'b1;
      end
    end
  endgenerate

  // Active high: a latched one lights its segment.
  assign seg_out = seg_q;
  assign frame_loaded = load_q;
  assign frame_overrun = overrun_q;
  assign frame_busy = (state_q != ST_IDLE);
  assign sclk_too_fast = too_fast_q;

endmodule // ssd_driver

// ---- src/ssd_map.vh ----
// Constants for the serial segment driver: frame layout, counts and timing.
`ifndef SSD_MAP_VH
`define SSD_MAP_VH

// Frame layout: one start bit followed by the data bits.
`define SSD_NUM_BITS 35
`define SSD_FRAME_CLKS 36
`define SSD_IDX_W 6
`define SSD_FIRST_IDX 6'h00
`define SSD_LAST_IDX 6'h22

// Output that a data-enable input replaces, counted from zero.
`define SSD_ENABLE_OUT_POS 34

// Reset values of the shift stages and the output latches.
`define SSD_SR_RESET 35'h0
`define SSD_LATCH_RESET 35'h0

// Depth of the frame buffer behind the latches.
`define SSD_FIFO_DEPTH 2
`define SSD_FIFO_AW 1

// Timing: system clock period and the fastest shift clock of each variant.
`define SSD_CLK_PERIOD_NS 40
`define SSD_VF_MAX_KHZ 250
`define SSD_LED_MAX_KHZ 500
`define SSD_VF_MIN_PERIOD_NS (1000000 / `SSD_VF_MAX_KHZ)
`define SSD_LED_MIN_PERIOD_NS (1000000 / `SSD_LED_MAX_KHZ)
`define SSD_VF_MIN_CYC ((`SSD_VF_MIN_PERIOD_NS + `SSD_CLK_PERIOD_NS - 1) / `SSD_CLK_PERIOD_NS)
`define SSD_LED_MIN_CYC ((`SSD_LED_MIN_PERIOD_NS + `SSD_CLK_PERIOD_NS - 1) / `SSD_CLK_PERIOD_NS)
`define SSD_GAP_W 8
`define SSD_GAP_MAX 8'hff

`endif

// ---- src/ssd_frame_fifo.v ----
// Two-entry frame buffer with valid and ready on both sides.
`timescale 1ns/1ps
`include "ssd_map.vh"

module ssd_frame_fifo #(
  parameter WIDTH = `SSD_NUM_BITS,
  parameter DEPTH = `SSD_FIFO_DEPTH,
  parameter AW = `SSD_FIFO_AW
) (
  // Clock and reset
  input wire clk,
  input wire arst_n,
  // Filling side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Draining side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_q;
  reg [AW-1:0] rd_ptr_q;
  reg [AW:0] count_q;
  wire push;
  wire pop;

  function [AW-1:0] ptr_inc;
    input [AW-1:0] p;
    begin
      if (p == DEPTH[AW-1:0] - 1'b1)
        ptr_inc = {AW{1'b0}};
      else
        ptr_inc = p + 1'b1;
    end
  endfunction

  assign in_ready = (count_q != DEPTH[AW:0]);
  assign out_valid = (count_q != {(AW+1){1'b0}});
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[rd_ptr_q];

  // Storage has no reset; out_data is only meaningful while out_valid is high.
  always @(posedge clk)
  begin
    if (push)
      mem[wr_ptr_q] <= in_data;
  end

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr_q <= ptr_inc(wr_ptr_q);
      if (pop)
        rd_ptr_q <= ptr_inc(rd_ptr_q);
      if (push && !pop)
        count_q <= count_q + 1'b1;
      else if (pop && !push)
        count_q <= count_q - 1'b1;
    end
  end

endmodule // ssd_frame_fifo

// ---- tb/ssd_driver_chk.sv ----
// Port-level checks for the serial segment driver.
`timescale 1ns/1ps
module ssd_driver_chk #(
  parameter NUM_BITS = 35
) (
  input wire clk,
  input wire arst_n,
  input wire sclk,
  input wire sdata,
  input wire data_en,
  input wire [NUM_BITS-1:0] seg_out,
  input wire [NUM_BITS-1:0] frame_data,
  input wire frame_valid,
  input wire frame_ready,
  input wire frame_loaded,
  input wire frame_overrun,
  input wire frame_busy,
  input wire sclk_too_fast
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_seg_only_load: assert property ($changed(seg_out) |-> frame_loaded)
    else $error("segments moved without a load");
  a_enable_slot: assert property (!seg_out[NUM_BITS-1])
    else $error("enable slot drove a segment");
  a_load_pulse: assert property (frame_loaded |=> !frame_loaded)
    else $error("load pulse too long");
  a_clear_after: assert property (frame_loaded |-> frame_busy)
    else $error("frame closed before its clear");
  a_off_frozen: assert property (!data_en |=> $stable(seg_out) && $stable(frame_busy))
    else $error("disabled driver changed state");
  a_start_seen: assert property ($rose(sclk) && sdata && data_en && !frame_busy |=> frame_busy)
    else $error("start bit not taken");
  a_zero_ignored: assert property ($rose(sclk) && !sdata && data_en && !frame_busy |=> !frame_busy)
    else $error("frame opened without start bit");
  a_load_queued: assert property (frame_loaded |=> frame_valid)
    else $error("loaded frame not queued");
  a_head_holds: assert property (frame_valid && !frame_ready |=> frame_valid && $stable(frame_data))
    else $error("buffer head lost while stalled");
  a_fast_in_frame: assert property (sclk_too_fast |-> frame_busy)
    else $error("rate flag outside a frame");
  c_fast: cover property (sclk_too_fast);
  c_load: cover property (frame_loaded);
  c_overrun: cover property (frame_overrun);
  c_pop: cover property (frame_valid && frame_ready);
endmodule // ssd_driver_chk

bind ssd_driver ssd_driver_chk #(.NUM_BITS(NUM_BITS)) chk_i (.clk(clk), .arst_n(arst_n), .sclk(sclk),
  .sdata(sdata), .data_en(data_en), .seg_out(seg_out), .frame_data(frame_data), .frame_valid(frame_valid),
  .frame_ready(frame_ready), .frame_loaded(frame_loaded), .frame_overrun(frame_overrun),
  .frame_busy(frame_busy), .sclk_too_fast(sclk_too_fast));

// ---- tb/ssd_src.sv ----
// Serial frame source standing in for the controlling logic.
`timescale 1ns/1ps
module ssd_src #(
  parameter HALF = 26
) (
  input wire clk,
  output reg sclk,
  output reg sdata,
  output reg data_en
);
  initial
  begin
    sclk = 1'b0;
    sdata = 1'b0;
    data_en = 1'b1;
  end
  // High phase spans h cycles, low phase h+1 before the next pulse; HALF keeps the period above the fastest legal rate.
  task pulse_h(input b, input integer h);
    begin
      @(posedge clk);
      sclk <= 1'b1;
      sdata <= b;
      repeat (h) @(posedge clk);
      sclk <= 1'b0;
      repeat (h) @(posedge clk);
    end
  endtask
  task pulse(input b);
    begin
      pulse_h(b, HALF);
    end
  endtask
  // Start bit, then bit one first; always the whole 36 clocks, and the data line flips once released.
  task send_h(input [34:0] d, input integer h);
    integer i;
    begin
      pulse_h(1'b1, h);
      for (i = 0; i < 35; i = i + 1)
        pulse_h(d[i], h);
      sdata <= ~sdata;
    end
  endtask
  task send(input [34:0] d);
    begin
      send_h(d, HALF);
    end
  endtask
  // Data-enable changes only at a clock edge, between frames.
  task set_en(input e);
    begin
      data_en <= e;
    end
  endtask
endmodule // ssd_src

// ---- tb/tb.sv ----
// Self-checking bench for the serial segment driver.
`timescale 1ns/1ps
`include "ssd_map.vh"
module tb;
  localparam NB = `SSD_NUM_BITS;
  reg clk;
  reg arst_n;
  reg frame_ready;
  reg ovr_seen;
  reg fast_seen;
  integer err_count;
  integer n_tests;
  integer cyc;
  wire sclk;
  wire sdata;
  wire data_en;
  wire [NB-1:0] seg_out;
  wire [NB-1:0] frame_data;
  wire frame_valid;
  wire frame_loaded;
  wire frame_overrun;
  wire frame_busy;
  wire sclk_too_fast;
  ssd_src ssd_src_i (.clk(clk), .sclk(sclk), .sdata(sdata), .data_en(data_en));
  ssd_driver ssd_driver_i (.clk(clk), .arst_n(arst_n), .sclk(sclk), .sdata(sdata), .data_en(data_en),
    .seg_out(seg_out), .frame_data(frame_data), .frame_valid(frame_valid), .frame_ready(frame_ready),
    .frame_loaded(frame_loaded), .frame_overrun(frame_overrun), .frame_busy(frame_busy),
    .sclk_too_fast(sclk_too_fast));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task conclude;
    begin
      $display("tests %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  task chk(input [NB-1:0] got, input [NB-1:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp)
      begin
        err_count = err_count + 1;
        $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  // The top output is replaced by the enable input, so it never lights.
  task sc(input [NB-1:0] d);
    begin
      ssd_src_i.send(d);
      chk(seg_out, {1'b0, d[NB-2:0]});
    end
  endtask
  task t_reset;
    begin
      chk(seg_out, 35'h0);
      chk(frame_valid, 1'b0);
      $display("t_reset done");
    end
  endtask
  task t_frames;
    begin
      sc(35'h1);
      sc(35'h7ffffffff);
      sc(35'h7ffffffff);
      sc(35'h2a5a5a5a5);
      sc(35'h400000000);
      $display("t_frames done");
    end
  endtask
  task t_idle;
    begin
      ssd_src_i.pulse(1'b0);
      sc(35'h0c3c3c3c3);
      $display("t_idle done");
    end
  endtask
  task t_disable;
    begin
      ssd_src_i.set_en(1'b0);
      ssd_src_i.send(35'h0f0f0f0f0);
      chk(seg_out, 35'h0c3c3c3c3);
      ssd_src_i.set_en(1'b1);
      sc(35'h155555555);
      $display("t_disable done");
    end
  endtask
  task t_buffer;
    begin
      frame_ready <= 1'b0;
      sc(35'h111111111);
      sc(35'h222222222);
      sc(35'h333333333);
      chk(ovr_seen, 1'b1);
      chk(frame_data, 35'h111111111);
      frame_ready <= 1'b1;
      @(posedge clk);
      frame_ready <= 1'b0;
      @(posedge clk);
      chk(frame_data, 35'h222222222);
      frame_ready <= 1'b1;
      @(posedge clk);
      @(posedge clk);
      chk(frame_valid, 1'b0);
      $display("t_buffer done");
    end
  endtask
  // A frame clocked faster than the variant allows still loads, but is flagged.
  task t_fast;
    begin
      chk(fast_seen, 1'b0);
      ssd_src_i.send_h(35'h0a5a5a5a5, 4);
      chk(fast_seen, 1'b1);
      chk(seg_out, 35'h0a5a5a5a5);
      $display("t_fast done");
    end
  endtask
  // A reset in mid-frame must drop the partial frame and clear the latches.
  task t_rearm;
    begin
      ssd_src_i.pulse(1'b1);
      ssd_src_i.pulse(1'b1);
      arst_n <= 1'b0;
      repeat (2) @(posedge clk);
      chk(seg_out, 35'h0);
      chk(frame_busy, 1'b0);
      arst_n <= 1'b1;
      sc(35'h0000000ff);
      $display("t_rearm done");
    end
  endtask
  always @(posedge clk)
  begin
    if (frame_overrun)
      ovr_seen <= 1'b1;
    if (sclk_too_fast)
      fast_seen <= 1'b1;
    cyc = cyc + 1;
    if (cyc == 40000)
    begin
      err_count = err_count + 1;
      $display("mismatch at %0t: run too long", $time);
      conclude;
    end
  end
  initial
  begin
    err_count = 0;
    n_tests = 0;
    cyc = 0;
    ovr_seen = 1'b0;
    fast_seen = 1'b0;
    frame_ready = 1'b1;
    arst_n = 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    t_reset;
    t_frames;
    t_idle;
    t_disable;
    t_buffer;
    t_fast;
    t_rearm;
    conclude;
  end
endmodule // tb
